// ---- logic/freq_trip_pkg.sv ----
// Constants, register map and types for the frequency trip logic.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
package freq_trip_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int LOSS_MS = 100;
    localparam int LOSS_CYCLES_DEF = LOSS_MS * MS_CYCLES_DEF;
    localparam int PER_W = 24;
    localparam int DLY_W = 16;
    localparam int NUM_SP = 4;
    localparam logic [2:0] PERSIST_CYCLES = 3'h3;
    localparam logic [2:0] PERSIST_SAT = 3'h4;
    localparam logic [PER_W-1:0] PER_MAX = 24'hFFFFFF;
    localparam logic [PER_W-1:0] PER_ONE = 24'h000001;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_OUTS = 8'h08;
    localparam logic [7:0] OFS_SP_BASE = 8'h10;
    localparam logic [7:0] OFS_SP_END = 8'h30;
    // Field positions
    localparam int CTRL_TRST_BIT = 8;
    localparam int STAT_PRESENT_BIT = 24;
    localparam int STAT_BLOCK_BIT = 25;
    localparam int CFG_ROC_BIT = 3;
    localparam int CFG_DLY_LSB = 16;
    // Reset values
    localparam logic [6:0] UV_CUT_RST = 7'h23;
    localparam logic [6:0] UV_FULL = 7'h64;
    localparam logic [PER_W-1:0] THR_RST = 24'h196E6B;
    localparam logic [DLY_W-1:0] DLY_RST = 16'h05DC;

    typedef enum logic [2:0] {
        MODE_UNDER = 3'h1,
        MODE_OVER = 3'h2,
        MODE_RESTORE = 3'h4
    } mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_TIMING = 4'h2,
        ST_ON = 4'h4,
        ST_HOLD = 4'h8
    } sp_state_t;

    // Byte-lane merge of a 32-bit write
    function automatic logic [31:0] merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage

// ---- logic/sp_if.sv ----
// Carrier between the trip top and one setpoint unit.
// Assumes one clock; the top drives the control side.
`timescale 1ns/1ns
interface sp_if;
    import freq_trip_pkg::*;
    logic [PER_W-1:0] period;
    logic cycle;
    logic clear;
    mode_t mode;
    logic [PER_W-1:0] thr;
    logic [DLY_W-1:0] delay_ms;
    logic ms_tick;
    logic converter;
    logic fe;
    logic timing;
    logic timer_on;
    modport unit(input period, cycle, clear, mode, thr, delay_ms, ms_tick,
        converter, output fe, timing, timer_on);
    modport ctrl(output period, cycle, clear, mode, thr, delay_ms, ms_tick,
        converter, input fe, timing, timer_on);
endinterface

// ---- logic/period_meter.sv ----
// Line period meter: counts clocks between rising edges of the line input.
// Assumes line_i is a squared, clock-synchronous copy of the AC input.
`timescale 1ns/1ns
module period_meter
    import freq_trip_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_i,
    input wire logic [PER_W-1:0] loss_cycles_i,
    output logic [PER_W-1:0] period_o,
    output logic cycle_o,
    output logic present_o
);
    logic line_reg;
    logic seen_reg;
    logic [PER_W-1:0] cnt_reg;
    wire rise = line_i & ~line_reg;
    wire lost = (cnt_reg >= loss_cycles_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_reg <= 1'b0;
            seen_reg <= 1'b0;
            cnt_reg <= '0;
            period_o <= '0;
            cycle_o <= 1'b0;
            present_o <= 1'b0;
        end else begin
            line_reg <= line_i;
            cycle_o <= rise & seen_reg & ~lost;
            if (rise) begin
                cnt_reg <= '0;
                seen_reg <= 1'b1;
                if (seen_reg && !lost) begin
                    period_o <= cnt_reg + PER_ONE;
                    present_o <= 1'b1;
                end
            end else if (lost) begin
                seen_reg <= 1'b0;
                present_o <= 1'b0;
                period_o <= '0;
            end else begin
                cnt_reg <= cnt_reg + PER_ONE;
            end
        end
    end
endmodule

// ---- logic/setpoint_unit.sv ----
// One frequency setpoint: cycle persistence and delay timer.
// Assumes the top asserts clear while the line is absent or blocked.
`timescale 1ns/1ns
module setpoint_unit
    import freq_trip_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    sp_if.unit sp
);
    logic [2:0] persist_reg;
    logic [2:0] persist_next;
    logic [DLY_W-1:0] ms_reg;
    sp_state_t state_reg;
    sp_state_t state_next;

    wire deviate = (sp.mode == MODE_UNDER) ? (sp.period > sp.thr)
                                           : (sp.period < sp.thr);
    wire restore = (sp.mode == MODE_RESTORE);
    wire fe_now = (persist_reg > PERSIST_CYCLES);
    wire expired = (ms_reg >= sp.delay_ms);

    assign persist_next = sp.clear ? 3'h0 :
        !sp.cycle ? persist_reg :
        !deviate ? 3'h0 :
        (persist_reg == PERSIST_SAT) ? persist_reg : persist_reg + 3'h1;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fe_now) begin
                    state_next = restore ? ST_ON : ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (!fe_now) begin
                    state_next = ST_IDLE;
                end else if (expired) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (!fe_now) begin
                    state_next = restore ? ST_HOLD : ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (fe_now) begin
                    state_next = ST_ON;
                end else if (expired) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (sp.clear) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            persist_reg <= 3'h0;
            state_reg <= ST_IDLE;
            ms_reg <= '0;
        end else begin
            persist_reg <= persist_next;
            state_reg <= state_next;
            if (state_next != state_reg) begin
                ms_reg <= '0;
            end else if (sp.ms_tick && !expired) begin
                ms_reg <= ms_reg + 16'h0001;
            end
        end
    end

    assign sp.fe = fe_now;
    assign sp.timing = (state_reg == ST_TIMING);
    assign sp.timer_on = (state_reg == ST_ON || state_reg == ST_HOLD)
        && (!restore || sp.converter);
endmodule

// ---- logic/freq_trip_top.sv ----
// Frequency trip logic: four setpoints, register file, trip outputs.
// Assumes a classic Wishbone master and clock-synchronous pin inputs.
//
// Operation
// - An under-frequency element asserts only after the frequency stays below its setpoint for more than three cycles.
// - In under and over mode, after an element asserts its delay runs, then the timer output, contact and trip target come on.
// - While voltage is below the cutoff the element, timer and contact outputs are held off and no target sets, and a 100% cutoff blocks everything.
// - Loss of the line input drops contacts, element and timer indications, which are not latched.
// - The rate-of-change option exists per setpoint except the last one in the chain.
// - With rate-of-change on, reaching the next lower setpoint before the first delay ends trips at once.
// - Crossing only the first setpoint trips after its full delay.
// - A rate trip raises timer outputs and rate targets at once while trip targets follow each delay.
// - A restore output exists only while the contact converter input is energized.
// - In restore mode the timer output and contact stay on for the delay after the element drops.
// - Each setpoint runs in under, over or restore mode.
// - Trip targets latch and clear only on target reset or power loss.
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module freq_trip_top
    import freq_trip_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter int LOSS_CYCLES = LOSS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    output logic ack_o,
    input wire logic line_i,
    input wire logic [6:0] volt_pct_i,
    input wire logic converter_i,
    input wire logic target_reset_i,
    output logic [NUM_SP-1:0] freq_element_o,
    output logic [NUM_SP-1:0] timer_output_indicator_o,
    output logic [NUM_SP-1:0] contact_o,
    output logic [NUM_SP-1:0] trip_target_o,
    output logic [NUM_SP-1:0] rate_trip_indicator_o
);
    localparam logic [PER_W-1:0] LOSS_W = PER_W'(LOSS_CYCLES);
    localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

    // Control and configuration
    logic [6:0] uv_cut_reg;
    logic trst_reg;
    logic [PER_W-1:0] thr_reg [NUM_SP];
    mode_t mode_reg [NUM_SP];
    logic [NUM_SP-1:0] rate_of_change_select;
    logic [DLY_W-1:0] dly_reg [NUM_SP];

    // Timebase and measurement
    logic [16:0] tick_cnt_reg;
    logic ms_tick_reg;
    logic [PER_W-1:0] period;
    logic cycle;
    logic present;
    logic block_reg;
    logic roc_run_reg;

    // Per-setpoint results
    logic [NUM_SP-1:0] fe;
    logic [NUM_SP-1:0] timing;
    logic [NUM_SP-1:0] timer_on;
    logic [NUM_SP-1:0] roc_hit;
    logic [NUM_SP-1:0] timer_out;

    period_meter meter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i(line_i),
        .loss_cycles_i(LOSS_W),
        .period_o(period),
        .cycle_o(cycle),
        .present_o(present)
    );

    wire uv_block = (volt_pct_i < uv_cut_reg) || (uv_cut_reg >= UV_FULL);
    wire clear_all = block_reg | ~present;

    genvar g;
    generate
        for (g = 0; g < NUM_SP; g++) begin : gen_sp
            sp_if sp();
            assign sp.period = period;
            assign sp.cycle = cycle;
            assign sp.clear = clear_all;
            assign sp.mode = mode_reg[g];
            assign sp.thr = thr_reg[g];
            assign sp.delay_ms = dly_reg[g];
            assign sp.ms_tick = ms_tick_reg;
            assign sp.converter = converter_i;
            assign fe[g] = sp.fe;
            assign timing[g] = sp.timing;
            assign timer_on[g] = sp.timer_on;
            setpoint_unit unit (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .sp(sp.unit)
            );
        end
    endgenerate

    generate
        for (g = 0; g < NUM_SP; g++) begin : gen_roc
            if (g < NUM_SP - 1) begin : g_chain
                assign roc_hit[g] = rate_of_change_select[g] & fe[g]
                    & timing[g] & fe[g+1];
            end else begin : g_last
                assign roc_hit[g] = 1'b0;
            end
        end
    endgenerate

    assign timer_out = timer_on | ({NUM_SP{roc_run_reg}} & fe);

    // Bus decode
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i;
    wire hit_ctrl = (adr_i == OFS_CTRL);
    wire hit_status = (adr_i == OFS_STATUS);
    wire hit_outs = (adr_i == OFS_OUTS);
    wire hit_sp = (adr_i >= OFS_SP_BASE) && (adr_i < OFS_SP_END);
    wire [7:0] sp_off = adr_i - OFS_SP_BASE;
    wire [1:0] sp_idx = sp_off[4:3];
    wire sp_cfg = sp_off[2];
    wire [31:0] ctrl_word = {25'h0, uv_cut_reg};
    wire [31:0] status_word = {6'h0, block_reg, present, period};
    wire [31:0] outs_word = {16'h0, rate_trip_indicator_o, trip_target_o,
        timer_output_indicator_o, freq_element_o};
    wire [31:0] thr_word = {8'h0, thr_reg[sp_idx]};
    wire [31:0] cfg_word = {dly_reg[sp_idx], 12'h0,
        rate_of_change_select[sp_idx], mode_reg[sp_idx]};
    wire [31:0] ctrl_wr = merge(ctrl_word, dat_i, sel_i);
    wire [31:0] thr_wr = merge(thr_word, dat_i, sel_i);
    wire [31:0] cfg_wr = merge(cfg_word, dat_i, sel_i);
    wire [2:0] mode_wr = cfg_wr[2:0];
    wire mode_ok = (mode_wr == MODE_UNDER) || (mode_wr == MODE_OVER)
        || (mode_wr == MODE_RESTORE);
    wire [31:0] rd_data = hit_ctrl ? ctrl_word :
        hit_status ? status_word :
        hit_outs ? outs_word :
        (hit_sp && !sp_cfg) ? thr_word :
        (hit_sp && sp_cfg) ? cfg_word : 32'h0;
    wire target_clear = trst_reg | target_reset_i;

    // Bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            dat_o <= req ? rd_data : 32'h0;
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_cut_reg <= UV_CUT_RST;
            trst_reg <= 1'b0;
        end else begin
            trst_reg <= wr & hit_ctrl & sel_i[1] & dat_i[CTRL_TRST_BIT];
            if (wr && hit_ctrl) begin
                uv_cut_reg <= ctrl_wr[6:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_of_change_select <= '0;
            for (int i = 0; i < NUM_SP; i++) begin
                thr_reg[i] <= THR_RST;
                mode_reg[i] <= MODE_UNDER;
                dly_reg[i] <= DLY_RST;
            end
        end else if (wr && hit_sp) begin
            if (!sp_cfg) begin
                thr_reg[sp_idx] <= thr_wr[PER_W-1:0];
            end else begin
                if (mode_ok) begin
                    mode_reg[sp_idx] <= mode_t'(mode_wr);
                end
                dly_reg[sp_idx] <= cfg_wr[CFG_DLY_LSB +: DLY_W];
                rate_of_change_select[sp_idx] <= cfg_wr[CFG_ROC_BIT]
                    & (sp_idx != 2'(NUM_SP - 1));
            end
        end
    end

    // Millisecond timebase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 17'h0;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_tick_reg <= (tick_cnt_reg == MS_LAST);
            tick_cnt_reg <= (tick_cnt_reg == MS_LAST) ? 17'h0
                : tick_cnt_reg + 17'h1;
        end
    end

    // Voltage block register and rate trip run flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            block_reg <= 1'b0;
            roc_run_reg <= 1'b0;
        end else begin
            block_reg <= uv_block;
            if (clear_all || fe == '0) begin
                roc_run_reg <= 1'b0;
            end else if (roc_hit != '0) begin
                roc_run_reg <= 1'b1;
            end
        end
    end

    // Indications and contacts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_element_o <= '0;
            timer_output_indicator_o <= '0;
            contact_o <= '0;
        end else begin
            freq_element_o <= fe & {NUM_SP{~clear_all}};
            timer_output_indicator_o <= timer_out & {NUM_SP{~clear_all}};
            contact_o <= timer_out & {NUM_SP{~clear_all}};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_target_o <= '0;
            rate_trip_indicator_o <= '0;
        end else begin
            trip_target_o <= (target_clear ? '0 : trip_target_o)
                | (timer_on & {NUM_SP{~clear_all}});
            rate_trip_indicator_o <= (target_clear ? '0
                : rate_trip_indicator_o)
                | (roc_hit & {NUM_SP{~clear_all}});
        end
    end
endmodule

// ---- dv/line_model.sv ----
// Model of the monitored AC line: a squared wave of set period.
// Assumes the trip logic samples it on the same clock.
`timescale 1ns/1ns
module line_model (
    input wire logic clk_i,
    input wire logic on_i,
    input wire logic [15:0] per_i,
    output logic line_o
);
    logic [15:0] cnt_reg;
    // Period counter, held at zero while the line is removed
    always_ff @(posedge clk_i) begin
        if (!on_i || cnt_reg >= per_i - 16'h0001) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
    // Removed line stays low, so no crossings
    assign line_o = on_i && (cnt_reg < (per_i >> 1));
endmodule

// ---- dv/freq_trip_checker.sv ----
// Assertions on the ports of the frequency trip top.
// Assumes a classic Wishbone master and a synchronous line input.
`timescale 1ns/1ns
module freq_trip_checker
    import freq_trip_pkg::*;
#(
    parameter int LOSS_CYCLES = LOSS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic stb_i,
    input wire logic cyc_i,
    input wire logic ack_o,
    input wire logic line_i,
    input wire logic [6:0] volt_pct_i,
    input wire logic target_reset_i,
    input wire logic [NUM_SP-1:0] freq_element_o,
    input wire logic [NUM_SP-1:0] timer_output_indicator_o,
    input wire logic [NUM_SP-1:0] trip_target_o,
    input wire logic [NUM_SP-1:0] rate_trip_indicator_o
);
    localparam logic [23:0] LOSS_LIM = 24'(LOSS_CYCLES + 8);
    logic [6:0] cut_reg;
    logic [23:0] idle_reg;
    logic [3:0] rise_reg;
    logic [1:0] quiet_reg;
    logic line_reg;
    wire take = cyc_i && stb_i && !ack_o;
    wire ctrl_wr = take && we_i && adr_i == OFS_CTRL;
    wire blk = volt_pct_i < cut_reg || cut_reg >= UV_FULL;
    wire rise = line_i && !line_reg;
    wire lost = idle_reg > LOSS_LIM;
    wire clr = target_reset_i || (ctrl_wr && sel_i[1] && dat_i[CTRL_TRST_BIT]);
    wire [3:0] outs = freq_element_o | timer_output_indicator_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cut_reg <= UV_CUT_RST;
            idle_reg <= 24'h000000;
            rise_reg <= 4'h0;
            quiet_reg <= 2'h0;
            line_reg <= 1'b0;
        end else begin
            line_reg <= line_i;
            if (ctrl_wr && sel_i[0]) begin
                cut_reg <= dat_i[6:0];
            end
            idle_reg <= rise ? 24'h000000 : idle_reg + {23'h0, !lost};
            rise_reg <= lost ? {3'h0, rise} :
                rise_reg + {3'h0, rise && rise_reg != 4'hF};
            quiet_reg <= clr ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        take;
    endsequence
    sequence s_answer;
        ack_o ##1 !ack_o;
    endsequence
    property p_bus_answer;
        s_take |=> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered once");
    property p_block;
        blk [*3] |-> outs == 4'h0;
    endproperty
    a_block: assert property (p_block)
        else $error("output active under voltage cutoff");
    property p_target_timer;
        (trip_target_o & ~$past(trip_target_o) & ~timer_output_indicator_o
            & ~$past(timer_output_indicator_o)) == 4'h0;
    endproperty
    a_target_timer: assert property (p_target_timer)
        else $error("trip target set without timer output");
    property p_last_rate;
        rate_trip_indicator_o[NUM_SP-1] == 1'b0;
    endproperty
    a_last_rate: assert property (p_last_rate)
        else $error("rate target on last setpoint");
    property p_latched;
        quiet_reg == 2'h3 |->
            (trip_target_o & $past(trip_target_o)) == $past(trip_target_o);
    endproperty
    a_latched: assert property (p_latched)
        else $error("trip target dropped without reset");
    property p_persist;
        $rose(|freq_element_o) |-> rise_reg >= 4'h5;
    endproperty
    a_persist: assert property (p_persist)
        else $error("element asserted before four cycles");
    property p_loss;
        lost |-> outs == 4'h0;
    endproperty
    a_loss: assert property (p_loss)
        else $error("indication held after line loss");
    property p_rate_force;
        $rose(|rate_trip_indicator_o) |-> ##[0:2]
            (timer_output_indicator_o & freq_element_o) == freq_element_o;
    endproperty
    a_rate_force: assert property (p_rate_force)
        else $error("rate trip without timer outputs");
endmodule

bind freq_trip_top freq_trip_checker #(.LOSS_CYCLES(LOSS_CYCLES))
    freq_trip_checker_inst (.clk_i, .rst_i, .adr_i, .dat_i, .we_i, .sel_i,
    .stb_i, .cyc_i, .ack_o, .line_i, .volt_pct_i, .target_reset_i,
    .freq_element_o, .timer_output_indicator_o, .trip_target_o,
    .rate_trip_indicator_o);

// ---- dv/tb.sv ----
// Self-checking bench for the frequency trip top.
// Assumes the line model on the AC side and a Wishbone master here.
`timescale 1ns/1ns
module tb;
    import freq_trip_pkg::*;
    localparam int LOSS = 2000;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] v;
        logic [31:0] m;
    } note_t;
    note_t note_q[$];
    logic clk, rst, cyc, stb, we, ack, line, on, conv, trst;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, seed;
    logic [3:0] sel, elem, tmr, cont, trip, rate;
    logic [6:0] volt;
    logic [15:0] per, pv;
    int fail_count, checks_done, cyc_cnt;
    freq_trip_top #(.MS_CYCLES(10), .LOSS_CYCLES(LOSS)) freq_trip_top_inst (
        .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
        .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc), .ack_o(ack),
        .line_i(line), .volt_pct_i(volt), .converter_i(conv),
        .target_reset_i(trst), .freq_element_o(elem),
        .timer_output_indicator_o(tmr), .contact_o(cont),
        .trip_target_o(trip), .rate_trip_indicator_o(rate));
    line_model line_model_inst (.clk_i(clk), .on_i(on), .per_i(per),
        .line_o(line));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
            input logic [3:0] s, input logic [31:0] d);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, s, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v,
            input logic [31:0] m);
        note_q.push_back({a, v, m});
        bus(a, 1'b0, 4'hF, 32'h0);
    endtask
    task automatic cfg(input int i, input logic [23:0] t,
            input logic [31:0] c);
        bus(OFS_SP_BASE + 8'(8 * i), 1'b1, 4'hF, {8'h00, t});
        bus(OFS_SP_BASE + 8'(8 * i + 4), 1'b1, 4'hF, c);
    endtask
    // Compares each read, and the pins on reads of the outputs register
    always @(negedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && note_q.size() > 0) begin
            check(rdat & note_q[0].m, note_q[0].v);
            if (note_q[0].a == OFS_OUTS) begin
                check({16'h0, rate, trip, cont, elem} & note_q[0].m,
                    note_q[0].v);
                check({16'h0, rate, trip, tmr, elem} & note_q[0].m,
                    note_q[0].v);
            end
            void'(note_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 40000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        seed = 32'h00003688;
        {rst, cyc, stb, we, on, conv, trst} = 7'b1000000;
        {sel, adr, wdat, per, pv, volt} = {4'hF, 8'h00, 32'h0, 32'h0, 7'h50};
        fail_count = 0;
        checks_done = 0;
        cyc_cnt = 0;
        wt(10);
        rst <= 1'b0;
        rd(OFS_CTRL, {25'h0, UV_CUT_RST}, 32'hFFFFFFFF);
        rd(OFS_SP_BASE, {8'h00, THR_RST}, 32'hFFFFFFFF);
        rd(8'h14, {DLY_RST, 16'h0001}, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        volt <= 7'h24 + 7'(rnd() % 32'h41);
        for (int i = 0; i < NUM_SP; i++) begin
            cfg(i, 24'h000064, 32'h000A0001);
        end
        pv = 16'h0065 + 16'(rnd() % 32'h28);
        per <= pv;
        on <= 1'b1;
        wt(3 * pv + pv / 2);
        rd(OFS_OUTS, 32'h0, 32'h0000FFFF);
        wt(pv / 2 + 20);
        rd(OFS_OUTS, 32'h0000000F, 32'h0000FFFF);
        wt(120);
        rd(OFS_OUTS, 32'h00000FFF, 32'h0000FFFF);
        rd(OFS_STATUS, {8'h01, 8'h00, pv}, 32'h03FFFFFF);
        on <= 1'b0;
        wt(LOSS + 400);
        rd(OFS_OUTS, 32'h00000F00, 32'h0000FFFF);
        trst <= 1'b1;
        wt(3);
        trst <= 1'b0;
        wt(2);
        rd(OFS_OUTS, 32'h0, 32'h0000FFFF);
        for (int k = 0; k < 2; k++) begin
            bus(OFS_CTRL, 1'b1, 4'hF, {25'h0, k == 0 ? UV_FULL : UV_CUT_RST});
            if (k == 1) begin
                volt <= 7'(rnd() % 32'h23);
            end
            on <= 1'b1;
            wt(8 * pv + 200);
            rd(OFS_OUTS, 32'h0, 32'h0000FFFF);
            rd(OFS_STATUS, 32'h02000000, 32'h02000000);
            on <= 1'b0;
            wt(LOSS + 400);
        end
        volt <= 7'h24 + 7'(rnd() % 32'h41);
        cfg(0, 24'h000064, 32'h00140009);
        cfg(1, 24'h000064, 32'h00280001);
        cfg(2, 24'hFFFFFF, 32'h000A0001);
        cfg(3, 24'hFFFFFF, 32'h000A0009);
        rd(8'h2C, 32'h000A0001, 32'hFFFFFFFF);
        on <= 1'b1;
        wt(4 * pv + 30);
        rd(OFS_OUTS, 32'h00001033, 32'h0000FFFF);
        wt(250);
        rd(OFS_OUTS, 32'h00001133, 32'h0000FFFF);
        wt(200);
        rd(OFS_OUTS, 32'h00001333, 32'h0000FFFF);
        on <= 1'b0;
        wt(LOSS + 400);
        bus(OFS_CTRL, 1'b1, 4'h2, 32'h00000100);
        rd(OFS_OUTS, 32'h0, 32'h0000FFFF);
        rd(OFS_CTRL, {25'h0, UV_CUT_RST}, 32'hFFFFFFFF);
        bus(8'h14, 1'b1, 4'hF, 32'h000A0003);
        rd(8'h14, 32'h00000001, 32'h00000007);
        cfg(0, 24'h000064, 32'h000A0004);
        cfg(1, 24'h000064, 32'h000A0002);
        conv <= 1'b1;
        pv = 16'h0050 - 16'(rnd() % 32'h14);
        per <= pv;
        on <= 1'b1;
        wt(4 * pv + 30);
        rd(OFS_OUTS, 32'h00000013, 32'h000000FF);
        wt(120);
        rd(OFS_OUTS, 32'h00000033, 32'h000000FF);
        per <= 16'h0078;
        while (elem[0] !== 1'b0) @(posedge clk);
        wt(20);
        rd(OFS_OUTS, 32'h00000010, 32'h000000FF);
        wt(120);
        rd(OFS_OUTS, 32'h0, 32'h000000FF);
        conv <= 1'b0;
        per <= pv;
        wt(6 * pv + 200);
        rd(OFS_OUTS, 32'h00000023, 32'h000000FF);
        stop_test();
    end
endmodule
